// [uem_pkg.sv]
// Purpose: constants for the uncorrectable error mask and severity bank
// Assumes: one aligned 32-bit word per register on apb
// Notes: bit positions follow the error status layout of the port
package uem_pkg;
	// ======================================================
	// register byte offsets
	localparam logic [11:0] UEM_SUPPRESS_OFS = 12'h108;
	localparam logic [11:0] UEM_FATALITY_OFS = 12'h10c;
	localparam logic [11:0] UEM_IRQ_STAT_OFS = 12'h200;
	localparam logic [11:0] UEM_IRQ_MASK_OFS = 12'h204;
	localparam logic [11:0] UEM_EVT_STAT_OFS = 12'h208;
	// ======================================================
	// error bit positions
	localparam int UEM_TRAIN_BIT = 0;
	localparam int UEM_DLP_BIT = 4;
	localparam int UEM_SDOWN_BIT = 5;
	localparam int UEM_POISON_BIT = 12;
	localparam int UEM_FCP_BIT = 13;
	localparam int UEM_CTO_BIT = 14;
	localparam int UEM_CA_BIT = 15;
	localparam int UEM_UC_BIT = 16;
	localparam int UEM_RXOVF_BIT = 17;
	localparam int UEM_MALF_BIT = 18;
	localparam int UEM_ECRC_BIT = 19;
	localparam int UEM_UR_BIT = 20;
	localparam int UEM_ACS_BIT = 21;
	// writable bits of both registers; bits 3:1, 11:6, 31:22 are reserved
	localparam logic [31:0] UEM_IMPL_MASK = 32'h003f_f031;
	// ======================================================
	// reset values
	localparam logic [31:0] UEM_SUPPRESS_RST = 32'h0000_0000;
	localparam logic [31:0] UEM_FATALITY_RST = 32'h0006_2031;
	localparam logic [1:0] UEM_IRQ_MASK_RST = 2'h0;
	// interrupt status layout
	localparam int UEM_IRQ_FATAL_BIT = 0;
	localparam int UEM_IRQ_NONFATAL_BIT = 1;
endpackage

// [uem_bank.sv]
// Purpose: sticky mask and severity registers that gate error logging and messages
// Assumes: apb slave on pclk, error events are one-cycle pulses synchronous to pclk
// Notes: sticky registers reset only on the power-on reset, not on presetn
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns

// Operation
// - masked errors are neither logged nor reported
// - bit 0 masks training errors, resets zero
// - bit 4 masks data link protocol errors
// - bit 5 masks surprise down, downstream only
// - bit 12 masks poisoned packets
// - bit 13 masks flow control protocol errors
// - bit 14 masks completion timeout, resets zero
// - bit 15 masks completer abort, resets zero
// - bit 16 masks unexpected completion, resets zero
// - bit 17 masks receiver overflow
// - bit 18 masks malformed packets
// - bit 19 masks end-to-end crc errors
// - bit 20 masks unsupported request, resets zero
// - training severity resets fatal; bits 3:1 unsupported
// - surprise down severity only on downstream ports
module uem_bank
	import uem_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic clk_en,
	input wire logic downstream_port,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] err_event,
	output logic log_strobe,
	output logic [31:0] log_errors,
	output logic msg_fatal,
	output logic msg_nonfatal,
	output logic irq
);

	// ======================================================
	// bus decode
	logic wr_en;
	logic rd_en;
	logic [31:0] wmask;
	logic [31:0] suppress_q;
	logic [31:0] fatality_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [31:0] seen_q;
	logic [31:0] impl_bits;
	logic [31:0] live;
	logic [1:0] irq_set;

	// byte-lane strobes widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// merge a write into a register honouring lanes and writable bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite & clk_en;
	assign rd_en = psel & penable & ~pwrite;
	assign wmask = lane_mask(pstrb);

	// surprise down bits are only implemented on downstream ports
	always_comb begin
		impl_bits = UEM_IMPL_MASK;
		impl_bits[UEM_SDOWN_BIT] = downstream_port;
	end

	// unmapped offsets answer with an error and read zero
	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			unique case (paddr)
				UEM_SUPPRESS_OFS, UEM_FATALITY_OFS, UEM_IRQ_STAT_OFS,
				UEM_IRQ_MASK_OFS, UEM_EVT_STAT_OFS: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

	// ======================================================
	// sticky mask register; held across presetn, cleared only by power-on
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			suppress_q <= UEM_SUPPRESS_RST;
		end else if (wr_en && paddr == UEM_SUPPRESS_OFS) begin
			suppress_q <= merge(suppress_q, pwdata, wmask & impl_bits);
		end
	end

	// sticky severity register, one means fatal
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			fatality_q <= UEM_FATALITY_RST;
		end else if (wr_en && paddr == UEM_FATALITY_OFS) begin
			fatality_q <= merge(fatality_q, pwdata, wmask & impl_bits);
		end
	end

	// ======================================================
	// event gating: masked bits never reach log or message paths
	// each bit of live is one error type, e.g. bit 0 training, 4 data link,
	// 12 poisoned, 13 flow control, 17 overflow, 18 malformed, 19 crc
	assign live = err_event & impl_bits & ~suppress_q;

	// registered log and message strobes, one cycle each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			log_strobe <= 1'b0;
			log_errors <= 32'h0000_0000;
			msg_fatal <= 1'b0;
			msg_nonfatal <= 1'b0;
		end else if (clk_en) begin
			log_strobe <= |live;
			log_errors <= live;
			msg_fatal <= |(live & fatality_q);
			msg_nonfatal <= |(live & ~fatality_q);
		end
	end

	// ======================================================
	// interrupt status: set wins over a write-one clear in the same cycle
	assign irq_set = {|(live & ~fatality_q), |(live & fatality_q)};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 2'h0;
		end else if (clk_en) begin
			if (wr_en && paddr == UEM_IRQ_STAT_OFS && pstrb[0]) begin
				irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	// interrupt mask, one enables the matching status bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= UEM_IRQ_MASK_RST;
		end else if (wr_en && paddr == UEM_IRQ_MASK_OFS && pstrb[0]) begin
			irq_mask_q <= pwdata[1:0];
		end
	end

	// level interrupt from flops so it never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ======================================================
	// per-type unmasked event history, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (wr_en && paddr == UEM_EVT_STAT_OFS) begin
				seen_q <= (seen_q & ~(pwdata & wmask)) | live;
			end else begin
				seen_q <= seen_q | live;
			end
		end
	end

	// ======================================================
	// read data, registered in the setup cycle ahead of the access cycle; reserved bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					UEM_SUPPRESS_OFS: prdata <= suppress_q & impl_bits;
					UEM_FATALITY_OFS: prdata <= fatality_q & impl_bits;
					UEM_IRQ_STAT_OFS: prdata <= {30'h0000_0000, irq_stat_q};
					UEM_IRQ_MASK_OFS: prdata <= {30'h0000_0000, irq_mask_q};
					UEM_EVT_STAT_OFS: prdata <= seen_q;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// rd_en kept for clarity of the access phase; data is already loaded in setup
	logic unused_rd;
	assign unused_rd = rd_en;

endmodule

// [uem_rc_model.sv]
// Purpose: root complex stand-in that tallies error messages
// Assumes: messages arrive as one-cycle pulses on pclk
// Notes: tallies wrap at 255, far more than one run sends
`timescale 1ns/1ns
module uem_rc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic msg_fatal,
	input wire logic msg_nonfatal,
	output logic [7:0] n_fat,
	output logic [7:0] n_nf
);
	// ==========
	// tallies clear with the port reset, like the receiving logic would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_fat <= 8'h0;
			n_nf <= 8'h0;
		end else begin
			n_fat <= n_fat + 8'(msg_fatal);
			n_nf <= n_nf + 8'(msg_nonfatal);
		end
	end
endmodule

// [uem_bank_chk.sv]
// Purpose: port assertions for the error mask bank
// Assumes: one pclk domain, presetn disables
// Notes: mask state is internal, so outputs are tied to their input causes
`timescale 1ns/1ns
module uem_bank_chk
	import uem_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] err_event,
	input wire logic log_strobe,
	input wire logic [31:0] log_errors,
	input wire logic msg_fatal,
	input wire logic msg_nonfatal
);
	// ==========
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_quiet;
		err_event == 32'h0;
	endsequence
	sequence s_rd_bank;
		psel && penable && !pwrite && (paddr == UEM_SUPPRESS_OFS || paddr == UEM_FATALITY_OFS);
	endsequence
	chk_quiet_out: assert property (s_quiet |=> !log_strobe && !msg_fatal && !msg_nonfatal)
		else $error("output without event");
	chk_log_cause: assert property (log_strobe |-> log_errors != 32'h0 &&
		(log_errors & ~$past(err_event)) == 32'h0) else $error("logged bit had no event");
	chk_rsvd_nolog: assert property ((log_errors & ~UEM_IMPL_MASK) == 32'h0)
		else $error("reserved type logged");
	chk_msg_logged: assert property (msg_fatal || msg_nonfatal |-> log_strobe)
		else $error("message without log");
	chk_one_class: assert property ($onehot($past(err_event)) |-> !(msg_fatal && msg_nonfatal))
		else $error("one event gave two classes");
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("access not answered");
	chk_slverr_phase: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access");
	chk_rsvd_read: assert property (s_rd_bank |-> (prdata & ~UEM_IMPL_MASK) == 32'h0)
		else $error("reserved bits read nonzero");
endmodule

// [tb.sv]
// Purpose: self-checking bench for the error mask bank
// Assumes: zero-wait apb slave, events as one-cycle pulses
// Notes: expected values are worked out here, not read from the design
`timescale 1ns/1ns
module tb
	import uem_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, dsp = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, log_strobe, msg_fatal, msg_nonfatal, irq, se;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, err_event = 32'h0, prdata, log_errors, rd, le;
	logic [2:0] lf;
	logic [7:0] n_fat, n_nf;
	logic iv;
	logic ce = 1'b1;
	int num_errors = 0, compares = 0, cyc = 0;
	uem_bank i_dut (.pclk, .presetn, .por_n, .clk_en(ce), .downstream_port(dsp), .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.err_event, .log_strobe, .log_errors, .msg_fatal, .msg_nonfatal, .irq);
	uem_rc_model i_rc (.pclk, .presetn, .msg_fatal, .msg_nonfatal, .n_fat, .n_nf);
	// ==========
	// clock and hang guard
	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end
	// ==========
	// shared tasks
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one transfer; request held until pready is seen high, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// pulse events; flags sampled one cycle on, irq after its extra lag
	task automatic ev(input logic [31:0] b);
		err_event <= b;
		@(posedge pclk);
		err_event <= 32'h0;
		#1 lf = {log_strobe, msg_fatal, msg_nonfatal};
		le = log_errors;
		repeat (2) @(posedge pclk);
		#1 iv = irq;
		@(posedge pclk);
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		apb(1'b0, UEM_SUPPRESS_OFS, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b0, UEM_FATALITY_OFS, 32'h0);
		cmp(rd, 32'h0006_2031);
	endtask
	task automatic t_mask;
		int bl[13] = '{0, 4, 5, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
		logic [31:0] fat = 32'h0006_2031, m, ef = 32'h0, en = 32'h0;
		foreach (bl[i]) begin
			m = 32'h1 << bl[i];
			apb(1'b1, UEM_SUPPRESS_OFS, m);
			ev(m);
			cmp({29'h0, lf}, 32'h0);
			apb(1'b1, UEM_SUPPRESS_OFS, 32'h003f_f031 ^ m);
			ev(32'h003f_f031);
			cmp(le, m);
			cmp({29'h0, lf}, {29'h0, 1'b1, fat[bl[i]], !fat[bl[i]]});
			ef += {31'h0, fat[bl[i]]};
			en += {31'h0, !fat[bl[i]]};
		end
		cmp({24'h0, n_fat}, ef);
		cmp({24'h0, n_nf}, en);
	endtask
	task automatic t_rsvd;
		apb(1'b1, UEM_SUPPRESS_OFS, 32'h0);
		ev(32'hffff_ffff);
		cmp(le, 32'h003f_f031);
		apb(1'b1, UEM_FATALITY_OFS, 32'hffff_ffff);
		dsp <= 1'b0;
		apb(1'b0, UEM_FATALITY_OFS, 32'h0);
		cmp(rd, 32'h003f_f011);
		apb(1'b1, UEM_FATALITY_OFS, 32'h0);
		dsp <= 1'b1;
		apb(1'b0, UEM_FATALITY_OFS, 32'h0);
		cmp(rd, 32'h0000_0020);
	endtask
	task automatic t_irq;
		apb(1'b1, UEM_IRQ_STAT_OFS, 32'h3);
		apb(1'b1, UEM_FATALITY_OFS, 32'h0000_0010);
		apb(1'b1, UEM_IRQ_MASK_OFS, 32'h1);
		ev(32'h0000_0010);
		cmp({31'h0, iv}, 32'h1);
		apb(1'b0, UEM_IRQ_STAT_OFS, 32'h0);
		cmp(rd, 32'h1);
		apb(1'b1, UEM_IRQ_STAT_OFS, 32'h1);
		@(posedge pclk);
		#1 cmp({31'h0, irq}, 32'h0);
		@(posedge pclk);
		apb(1'b1, UEM_IRQ_MASK_OFS, 32'h0);
		ev(32'h0000_0010);
		cmp({31'h0, iv}, 32'h0);
	endtask
	task automatic t_sticky;
		apb(1'b1, UEM_SUPPRESS_OFS, 32'h0010_4010);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, UEM_SUPPRESS_OFS, 32'h0);
		cmp(rd, 32'h0010_4010);
		apb(1'b0, 12'h300, 32'h0);
		cmp({rd[31:1], se}, 32'h1);
		ce <= 1'b0;
		apb(1'b1, UEM_SUPPRESS_OFS, 32'h0);
		ce <= 1'b1;
		apb(1'b0, UEM_SUPPRESS_OFS, 32'h0);
		cmp(rd, 32'h0010_4010);
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_mask();
		t_rsvd();
		t_irq();
		t_sticky();
		conclude();
	end
endmodule
bind uem_bank uem_bank_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .err_event, .log_strobe, .log_errors, .msg_fatal, .msg_nonfatal);
